// ---- design/rcs_pkg.sv ----
// constants and carriers for the reset and clock switch controller
package rcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYSCTL  = 8'h00; // system_control_two
  localparam logic [7:0] OFS_WDCTL   = 8'h04; // watchdog_control_one
  localparam logic [7:0] OFS_STATUS  = 8'h08; // sticky events, read clears
  localparam logic [7:0] OFS_MASK    = 8'h0C;
  localparam logic [7:0] OFS_WUCTL   = 8'h10; // warm-up timer control
  localparam logic [7:0] OFS_WUCMP   = 8'h14; // warmup_compare_value
  localparam logic [7:0] OFS_STATE   = 8'h18; // clock mode and reset state

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SYS_HF_BIT  = 7; // high oscillator enable
  localparam int SYS_LF_BIT  = 6; // low oscillator enable
  localparam int SYS_SEL_BIT = 5; // 1 selects the low clock
  localparam int WD_EN_BIT   = 3;
  localparam int WD_OUT_BIT  = 2; // watchdog_output_select
  localparam int TR_OUT_BIT  = 1; // trap_output_select
  localparam int TR_RAM_BIT  = 0; // ram_trap_area_select
  localparam int WU_RUN_BIT  = 0;

  // ----------------------------------------------------------------
  // reset values and address areas
  // ----------------------------------------------------------------
  localparam logic [7:0]  SYSCTL_RST   = 8'h80; // high clock, running
  localparam logic [7:0]  WDCTL_RST    = 8'h0E; // reset-requesting outputs
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] SFR_LAST     = 16'h003F;
  localparam logic [15:0] RAM_FIRST    = 16'h0040;
  localparam logic [15:0] RAM_LAST     = 16'h023F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int HF_PERIOD_PS   = 62500;  // 16 MHz high clock
  localparam int STRETCH_PS     = 24 * HF_PERIOD_PS;
  localparam int PIN_MIN_PS     = 12 * HF_PERIOD_PS;
  localparam int STRETCH_CYC    = STRETCH_PS / CLK_PERIOD_PS; // longest
  localparam int PIN_MIN_CYC    =
    (PIN_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;         // least
  localparam int SYNC_CYC       = 4; // low/high clock alignment wait
  localparam logic [7:0] STRETCH_LOAD = 8'(STRETCH_CYC);
  localparam logic [7:0] PIN_MIN_LOAD = 8'(PIN_MIN_CYC);
  localparam logic [2:0] SYNC_LOAD    = 3'(SYNC_CYC);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_switched;
    logic warmup_done;
    logic watchdog_irq;
    logic trap_irq;
  } rcs_event_t;

  typedef enum logic [1:0] {
    MODE_NORMAL_SINGLE_CLOCK_MODE,
    MODE_NORMAL_DUAL_CLOCK_MODE,
    MODE_LOW_CLOCK_ONLY_MODE,
    MODE_SYNC
  } rcs_mode_t;

endpackage : rcs_pkg

// ---- design/rcs_top.sv ----
// reset merger, malfunction stretcher and clock switch supervisor
// What this block does
// - reset comes from the pin, address trap, watchdog and clock fault
// - any malfunction request holds internal reset for a bounded stretch
// - malfunction stretch is not cleared at power-up, may fire once
// - pin low for twelve high-clock periods resets the device
// - on release execution starts from the top-of-memory vector
// - reset loads the vector, clears interrupt state, enables watchdog
// - fetch from SFR or selected RAM raises an address trap
// - trap answers as reset or interrupt, RAM area selectable
// - illegal oscillator disable raises a system clock reset
// - on clock fault the write is dropped; reset then leaves only the high oscillator on
// - after selecting high clock, run on low clock until aligned
// - pin reset ends low-clock mode; restart in single-clock normal mode
// - after reset watchdog and trap both request reset
`timescale 1ns/1ps
module rcs_top
  import rcs_pkg::*;
(
  // clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // reset pin, active low, asynchronous
  input  wire logic        reset_pin_n,
  // core side
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        watchdog_req,
  output logic             core_reset_n,
  output logic             pc_load,
  output logic [15:0]      pc_value,
  output logic             intr_state_clear,
  output logic             watchdog_enable,
  // oscillators and clock select
  output logic             hf_osc_enable,
  output logic             lf_osc_enable,
  output logic             run_on_low_clock,
  output rcs_mode_t        clock_mode,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        pin_meta;
  logic        pin_sync;
  logic [7:0]  pin_low_cnt;
  logic        pin_reset;
  logic [7:0]  stretch_cnt;
  logic [7:0]  sysctl;
  logic [7:0]  wdctl;
  rcs_event_t  status;
  rcs_event_t  mask;
  logic        wu_run;
  logic [15:0] wu_cmp;
  logic [15:0] wu_cnt;
  rcs_mode_t   mode;
  logic [2:0]  sync_cnt;
  logic        dp_write;
  logic [7:0]  dp_addr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        ap_take   = hsel && htrans[1] && hready;
  wire        ap_read   = ap_take && !hwrite;
  wire [7:0]  ap_addr   = haddr[7:0];
  wire        wr_sys    = dp_write && (dp_addr == OFS_SYSCTL);
  wire        wr_wd     = dp_write && (dp_addr == OFS_WDCTL);
  wire        wr_mask   = dp_write && (dp_addr == OFS_MASK);
  wire        wr_wuctl  = dp_write && (dp_addr == OFS_WUCTL);
  wire        wr_wucmp  = dp_write && (dp_addr == OFS_WUCMP);
  wire        rd_status = ap_read && (ap_addr == OFS_STATUS);

  // read mux, unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (ap_addr)
      OFS_SYSCTL: rd_mux = {24'h00_0000, sysctl};
      OFS_WDCTL:  rd_mux = {24'h00_0000, wdctl};
      OFS_STATUS: rd_mux = {28'h000_0000, status};
      OFS_MASK:   rd_mux = {28'h000_0000, mask};
      OFS_WUCTL:  rd_mux = {31'h0000_0000, wu_run};
      OFS_WUCMP:  rd_mux = {16'h0000, wu_cmp};
      OFS_STATE:  rd_mux = {29'h0000_0000, !core_reset_n, mode};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  wire new_hf  = hwdata[SYS_HF_BIT];
  wire new_lf  = hwdata[SYS_LF_BIT];
  wire sel_low = sysctl[SYS_SEL_BIT];

  // illegal oscillator disables
  wire clk_fault = wr_sys && core_reset_n &&
                   ((!new_hf && !new_lf) ||
                    (!new_hf && !sel_low) ||
                    (!new_lf && sel_low));

  wire trap_hit = fetch_valid && core_reset_n &&
                  (in_range(fetch_addr, 16'h0000, SFR_LAST) ||
                   (wdctl[TR_RAM_BIT] &&
                    in_range(fetch_addr, RAM_FIRST, RAM_LAST)));
  wire trap_rst = trap_hit && wdctl[TR_OUT_BIT];
  wire trap_int = trap_hit && !wdctl[TR_OUT_BIT];
  wire wd_rst   = watchdog_req && wdctl[WD_OUT_BIT];
  wire wd_int   = watchdog_req && !wdctl[WD_OUT_BIT];

  // malfunction requests share one stretcher
  wire malf_req = trap_rst || wd_rst || clk_fault;

  // merged reset, held until every source is quiet
  wire next_reset = pin_reset || malf_req ||
                    (stretch_cnt != 8'h00);

  // ----------------------------------------------------------------
  // pin synchroniser and low-time filter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      pin_meta <= reset_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // reset only after the pin stays low for the minimum time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_low_cnt <= 8'h00;
      pin_reset   <= 1'b0;
    end
    else if (pin_sync)
    begin
      pin_low_cnt <= 8'h00;
      pin_reset   <= 1'b0;
    end
    else
    begin
      if (pin_low_cnt < PIN_MIN_LOAD)
        pin_low_cnt <= pin_low_cnt + 8'h01;
      if (pin_low_cnt >= PIN_MIN_LOAD - 8'h01)
        pin_reset <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // malfunction stretch, loaded full at power-up
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stretch_cnt <= STRETCH_LOAD;
    else if (malf_req)
      stretch_cnt <= STRETCH_LOAD - 8'h01;
    else if (stretch_cnt != 8'h00)
      stretch_cnt <= stretch_cnt - 8'h01;
  end

  // ----------------------------------------------------------------
  // core reset, vector load and state clears
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_reset_n     <= 1'b0;
      intr_state_clear <= 1'b1;
      pc_load          <= 1'b0;
      pc_value         <= RESET_VECTOR;
    end
    else
    begin
      core_reset_n     <= !next_reset;
      intr_state_clear <= next_reset;
      pc_load          <= !core_reset_n && !next_reset;
      pc_value         <= RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // control registers, restored while core is in reset
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sysctl <= SYSCTL_RST;
    else if (!core_reset_n)
      sysctl <= SYSCTL_RST;
    else if (wr_sys && !clk_fault)
      sysctl <= hwdata[7:0] & 8'hE0;
    // a faulting write is dropped; the reset it raises then reloads SYSCTL_RST, leaving only the high oscillator on
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdctl <= WDCTL_RST;
    else if (!core_reset_n)
      wdctl <= WDCTL_RST;
    else if (wr_wd)
      wdctl <= hwdata[7:0] & 8'h0F;
  end

  // ----------------------------------------------------------------
  // clock switch: low to high waits for alignment
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode     <= MODE_NORMAL_SINGLE_CLOCK_MODE;
      sync_cnt <= 3'h0;
    end
    else if (!core_reset_n)
    begin
      mode     <= MODE_NORMAL_SINGLE_CLOCK_MODE;
      sync_cnt <= 3'h0;
    end
    else
    begin
      case (mode)
        MODE_NORMAL_SINGLE_CLOCK_MODE, MODE_NORMAL_DUAL_CLOCK_MODE:
        begin
          if (sel_low)
            mode <= MODE_LOW_CLOCK_ONLY_MODE;
          else
            mode <= sysctl[SYS_LF_BIT] ? MODE_NORMAL_DUAL_CLOCK_MODE : MODE_NORMAL_SINGLE_CLOCK_MODE;
        end
        MODE_LOW_CLOCK_ONLY_MODE:
        begin
          if (!sel_low)
          begin
            mode     <= MODE_SYNC;
            sync_cnt <= SYNC_LOAD;
          end
        end
        MODE_SYNC:
        begin
          if (sync_cnt == 3'h1)
            mode <= MODE_NORMAL_DUAL_CLOCK_MODE;
          sync_cnt <= sync_cnt - 3'h1;
        end
        default: mode <= MODE_NORMAL_SINGLE_CLOCK_MODE;
      endcase
    end
  end

  wire switched = (mode == MODE_SYNC) && (sync_cnt == 3'h1);

  // ----------------------------------------------------------------
  // warm-up timer used by software before leaving the low clock
  // ----------------------------------------------------------------
  wire wu_hit = wu_run && (wu_cnt == wu_cmp);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wu_run <= 1'b0;
      wu_cmp <= 16'hFFFF;
      wu_cnt <= 16'h0000;
    end
    else if (!core_reset_n)
    begin
      wu_run <= 1'b0;
      wu_cnt <= 16'h0000;
    end
    else
    begin
      if (wr_wuctl)
        wu_run <= hwdata[WU_RUN_BIT];
      if (wr_wucmp)
        wu_cmp <= hwdata[15:0];
      if (!wu_run || wu_hit)
        wu_cnt <= 16'h0000;
      else
        wu_cnt <= wu_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // events, mask and interrupt; set wins over read clear
  // ----------------------------------------------------------------
  rcs_event_t ev;
  rcs_event_t next_status;
  assign ev.trap_irq     = trap_int;
  assign ev.watchdog_irq = wd_int;
  assign ev.warmup_done  = wu_hit;
  assign ev.clk_switched = switched;
  assign next_status = (rd_status ? 4'h0 : status) | ev;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status <= 4'h0;
      mask   <= 4'h0;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (wr_mask)
        mask <= hwdata[3:0];
      irq <= |(next_status & (wr_mask ? hwdata[3:0] : mask));
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite handshake, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dp_write  <= ap_take && hwrite && (hsize == 3'h2);
      dp_addr   <= ap_addr;
      hrdata    <= ap_read ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs toward oscillators and core
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hf_osc_enable    <= 1'b1;
      lf_osc_enable    <= 1'b0;
      run_on_low_clock <= 1'b0;
      clock_mode       <= MODE_NORMAL_SINGLE_CLOCK_MODE;
      watchdog_enable  <= 1'b1;
    end
    else
    begin
      hf_osc_enable    <= sysctl[SYS_HF_BIT];
      lf_osc_enable    <= sysctl[SYS_LF_BIT];
      run_on_low_clock <= (mode == MODE_LOW_CLOCK_ONLY_MODE) ||
                          (mode == MODE_SYNC);
      clock_mode       <= mode;
      watchdog_enable  <= wdctl[WD_EN_BIT];
    end
  end

endmodule : rcs_top

// ---- bench/rcs_monitor.sv ----
// concurrent checks on the ports of the reset and clock switch controller
`timescale 1ns/1ps
module rcs_monitor
  import rcs_pkg::*;
(
  // clock and power-on reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // reset pin and core side
  input wire logic        reset_pin_n,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic        watchdog_req,
  input wire logic        core_reset_n,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value,
  input wire logic        intr_state_clear,
  input wire logic        watchdog_enable,
  // oscillators, mode and interrupt
  input wire logic        hf_osc_enable,
  input wire logic        lf_osc_enable,
  input wire logic        run_on_low_clock,
  input wire rcs_mode_t   clock_mode,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [8:0] low_cnt;
  // length of an internal reset while the pin is released
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_cnt <= 9'h000;
    else if (core_reset_n || !reset_pin_n)
      low_cnt <= 9'h000;
    else if (low_cnt != 9'h1FF)
      low_cnt <= low_cnt + 9'h001;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // sequences and assertions
  // ----------------------------------------------------------------
  sequence s_in_reset;
    !core_reset_n [*3];
  endsequence
  sequence s_sync_run;
    clock_mode == MODE_SYNC [*3];
  endsequence

  a_vector_fixed: assert property (pc_value == RESET_VECTOR)
    else $error("pc value is not the reset vector");
  a_load_after_rise: assert property ($rose(core_reset_n) |-> ##[0:1] pc_load)
    else $error("no pc load after reset release");
  a_load_in_run: assert property (pc_load |-> core_reset_n)
    else $error("pc load while in reset");
  a_stretch_bound: assert property (low_cnt <= 9'd152)
    else $error("malfunction reset held too long");
  a_reset_clears: assert property (s_in_reset |-> intr_state_clear && watchdog_enable)
    else $error("reset does not clear interrupts or enable watchdog");
  a_osc_alive: assert property (hf_osc_enable || lf_osc_enable)
    else $error("both oscillators stopped");
  a_reset_normal: assert property (s_in_reset |-> clock_mode == MODE_NORMAL_SINGLE_CLOCK_MODE && !run_on_low_clock)
    else $error("reset does not return to single clock mode");
  a_slow_no_jump: assert property (clock_mode == MODE_LOW_CLOCK_ONLY_MODE |=> clock_mode != MODE_NORMAL_DUAL_CLOCK_MODE)
    else $error("switch to high clock without alignment");
  a_sync_low: assert property ($rose(clock_mode == MODE_SYNC) |-> run_on_low_clock [*3])
    else $error("left low clock during alignment");
  a_sync_length: assert property ($rose(clock_mode == MODE_SYNC) |-> s_sync_run ##[1:3] clock_mode == MODE_NORMAL_DUAL_CLOCK_MODE)
    else $error("alignment does not end in dual clock mode");
endmodule : rcs_monitor

// ---- bench/test_rcs_top.sv ----
// self-checking bench for the reset and clock switch controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_rcs_top
  import rcs_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, reset_pin_n = 1'b1;
  logic fetch_valid = 1'b0, watchdog_req = 1'b0, ok;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [15:0] fetch_addr = 16'h0;
  logic hreadyout, hresp, core_reset_n, pc_load, intr_state_clear, watchdog_enable, irq;
  logic hf_osc_enable, lf_osc_enable, run_on_low_clock;
  logic [31:0] hrdata;
  logic [15:0] pc_value;
  rcs_mode_t clock_mode;
  wire logic hready;
  int failures = 0, tests_run = 0, len, i, k;
  logic [7:0] pre [3] = '{8'h80, 8'hC0, 8'hE0};
  logic [7:0] bad [3] = '{8'h00, 8'h40, 8'hA0};

  // clock and single-slave ready
  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  rcs_top rcs_top_inst (.*);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      conclude();
    end
  endtask : wait_ready
  // one single word transfer, address phase then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, rd);
    `CHK(nm, e, rd)
  endtask : rdc
  // one fetch cycle or one watchdog timeout pulse
  task strobe(input logic w, input logic [15:0] a);
    fetch_valid <= !w;
    fetch_addr <= a;
    watchdog_req <= w;
    @(posedge hclk);
    fetch_valid <= 1'b0;
    watchdog_req <= 1'b0;
  endtask : strobe
  task reset_len;
    for (i = 0; i < 300 && core_reset_n !== 1'b0; i++) @(posedge hclk);
    len = 0;
    while (core_reset_n === 1'b0 && len < 400)
    begin
      @(posedge hclk);
      len++;
    end
    // pc_load stands only in the first cycle after release, so take it here
    ok = pc_load;
    `CHK("reset length", 1'b1, (len >= STRETCH_CYC - 2 && len <= STRETCH_CYC + 3))
    repeat (2) @(posedge hclk);
  endtask : reset_len
  task quiet(input int n);
    ok = 1'b1;
    repeat (n)
    begin
      @(posedge hclk);
      ok = ok & core_reset_n;
    end
    `CHK("core_reset_n quiet", 1'b1, ok)
  endtask : quiet

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge hclk);
    `CHK("core_reset_n", 1'b0, core_reset_n)
    `CHK("intr_state_clear", 1'b1, intr_state_clear)
    `CHK("watchdog_enable", 1'b1, watchdog_enable)
    `CHK("osc enables", 2'b10, {hf_osc_enable, lf_osc_enable})
    hresetn <= 1'b1;
    reset_len();
    `CHK("pc_load", 1'b1, ok)
    `CHK("pc_value", RESET_VECTOR, pc_value)
    rdc(OFS_SYSCTL, {24'h0, SYSCTL_RST}, "sysctl");
    rdc(OFS_WDCTL, {24'h0, WDCTL_RST}, "wdctl");
    rdc(OFS_STATE, 32'h0, "state");
    rdc(8'h1C, 32'h0, "unmapped");
    strobe(1'b0, 16'h0010);
    reset_len();
    strobe(1'b0, 16'h0100);
    quiet(20);
    wr(OFS_WDCTL, 32'h0F);
    strobe(1'b0, 16'h0100);
    reset_len();
    strobe(1'b1, 16'h0);
    reset_len();
    wr(OFS_WDCTL, 32'h08);
    wr(OFS_MASK, 32'h0);
    strobe(1'b0, 16'h0020);
    strobe(1'b1, 16'h0);
    quiet(5);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_MASK, 32'h3);
    repeat (3) @(posedge hclk);
    `CHK("irq", 1'b1, irq)
    rdc(OFS_STATUS, 32'h3, "status");
    repeat (3) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    rdc(OFS_STATUS, 32'h0, "status cleared");
    for (k = 0; k < 3; k++)
    begin
      wr(OFS_SYSCTL, {24'h0, pre[k]});
      repeat (3) @(posedge hclk);
      wr(OFS_SYSCTL, {24'h0, bad[k]});
      reset_len();
    end
    wr(OFS_SYSCTL, 32'hE0);
    repeat (3) @(posedge hclk);
    rdc(OFS_STATE, 32'h2, "slow state");
    wr(OFS_SYSCTL, 32'h60);
    quiet(5);
    `CHK("hf off in slow", 2'b01, {hf_osc_enable, lf_osc_enable})
    wr(OFS_SYSCTL, 32'hE0);
    wr(OFS_WUCMP, 32'h20);
    wr(OFS_WUCTL, 32'h1);
    rd = 32'h0;
    for (i = 0; i < 30 && rd[2] !== 1'b1; i++) bus(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK("warm-up done", 1'b1, rd[2])
    wr(OFS_WUCTL, 32'h0);
    wr(OFS_SYSCTL, 32'hC0);
    @(posedge hclk);
    `CHK("low clock during alignment", 1'b1, run_on_low_clock)
    repeat (10) @(posedge hclk);
    `CHK("low clock after alignment", 1'b0, run_on_low_clock)
    rdc(OFS_STATE, 32'h1, "dual state");
    rdc(OFS_STATUS, 32'h8, "switched");
    wr(OFS_SYSCTL, 32'hE0);
    repeat (3) @(posedge hclk);
    reset_pin_n <= 1'b0;
    repeat (PIN_MIN_CYC + 10) @(posedge hclk);
    `CHK("pin reset", 1'b0, core_reset_n)
    `CHK("mode in reset", MODE_NORMAL_SINGLE_CLOCK_MODE, clock_mode)
    reset_pin_n <= 1'b1;
    for (i = 0; i < 20 && core_reset_n !== 1'b1; i++) @(posedge hclk);
    `CHK("pin release", 1'b1, core_reset_n)
    repeat (3) @(posedge hclk);
    rdc(OFS_SYSCTL, {24'h0, SYSCTL_RST}, "sysctl after pin");
    rdc(OFS_STATE, 32'h0, "state after pin");
    conclude();
  end
endmodule : test_rcs_top

bind rcs_top rcs_monitor rcs_monitor_inst (.*);
